//--- afmec_defines.svh
`ifndef AFMEC_DEFINES_SVH
`define AFMEC_DEFINES_SVH
// Behaviour
// - exactly one chained device has first-load low
// - all other chained devices hold first-load high
// - each expansion output feeds next expansion input
// - composite flags are or of device flags
// - width expansion: parallel controls, flags from one
// - write strobe toggles only while not full
// - read and write high during retransmit

// ----------------------------------------
// timing
// ----------------------------------------
`define AFMEC_CLK_NS 20
`define AFMEC_STROBE_NS 80
`define AFMEC_RECOV_NS 60
`define AFMEC_RESET_NS 100
`define AFMEC_CYC(ns) (((ns) + `AFMEC_CLK_NS - 1) / `AFMEC_CLK_NS)
`define AFMEC_STROBE_CYC `AFMEC_CYC(`AFMEC_STROBE_NS)
`define AFMEC_RECOV_CYC `AFMEC_CYC(`AFMEC_RECOV_NS)
`define AFMEC_RESET_CYC `AFMEC_CYC(`AFMEC_RESET_NS)

// ----------------------------------------
// geometry
// ----------------------------------------
`define AFMEC_LANE_BITS 9
`define AFMEC_MIN_DEPTH 256
`define AFMEC_MAX_DEPTH 8192
`define AFMEC_BUF_DEPTH 2
`endif

//--- afmec_pkg.sv
package afmec_pkg;
    timeunit 1ns;
    timeprecision 100ps;
    typedef enum logic [2:0] {
        AFMEC_ST_RESET,
        AFMEC_ST_IDLE,
        AFMEC_ST_WRITE,
        AFMEC_ST_READ,
        AFMEC_ST_RETRANS,
        AFMEC_ST_RECOV
    } afmec_state_t;

    // all strobes are active low at the pins
    typedef struct packed {
        logic pointer_reset_n;
        logic write_n;
        logic read_n;
        logic retransmit_strobe_n;
    } afmec_strobes_t;

    typedef struct packed {
        logic empty;
        logic full;
        logic half_full;
    } afmec_status_t;
endpackage : afmec_pkg

//--- afmec_host.sv
`include "afmec_defines.svh"

module afmec_host
    import afmec_pkg::*;
#(
    parameter int DEVS = 1,
    parameter int LANES = 1,
    parameter int DEV_DEPTH = 256
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic reset_req_in,
    input wire logic retransmit_req_in,
    input wire logic wr_valid_in,
    input wire logic [LANES*`AFMEC_LANE_BITS-1:0] wr_data_in,
    output logic wr_ready_out,
    output logic rd_valid_out,
    output logic [LANES*`AFMEC_LANE_BITS-1:0] rd_data_out,
    input wire logic rd_ready_in,
    output afmec_status_t status_out,
    output logic busy_out,
    output afmec_strobes_t fifo_ctrl_out,
    output logic [LANES*`AFMEC_LANE_BITS-1:0] fifo_data_out,
    input wire logic [LANES*`AFMEC_LANE_BITS-1:0] fifo_data_in,
    input wire logic [DEVS-1:0] empty_flag_n_in,
    input wire logic [DEVS-1:0] full_flag_n_in,
    input wire logic half_full_flag_n_in,
    output logic [DEVS-1:0] first_load_select_out
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int W = LANES * `AFMEC_LANE_BITS;
    localparam logic [3:0] STROBE_CYC = 4'(`AFMEC_STROBE_CYC);
    localparam logic [3:0] RECOV_CYC = 4'(`AFMEC_RECOV_CYC);
    localparam logic [3:0] RESET_CYC = 4'(`AFMEC_RESET_CYC);
    localparam logic SINGLE = (DEVS == 1);

    if (DEVS < 1 || LANES < 1 || DEV_DEPTH < `AFMEC_MIN_DEPTH
        || DEV_DEPTH > `AFMEC_MAX_DEPTH) begin : g_bad_params
        $error("afmec_host: unsupported DEVS, LANES or DEV_DEPTH");
    end

    // ----------------------------------------
    // flag and data synchronisers
    // ----------------------------------------
    logic [DEVS-1:0] empty_s1_reg, empty_s2_reg, full_s1_reg, full_s2_reg;
    logic half_s1_reg, half_s2_reg;
    logic [W-1:0] data_s1_reg, data_s2_reg;

    always_ff @(posedge sys_clk_in) begin
        empty_s1_reg <= empty_flag_n_in;
        empty_s2_reg <= empty_s1_reg;
        full_s1_reg <= full_flag_n_in;
        full_s2_reg <= full_s1_reg;
        half_s1_reg <= half_full_flag_n_in;
        half_s2_reg <= half_s1_reg;
        data_s1_reg <= fifo_data_in;
        data_s2_reg <= data_s1_reg;
    end

    // composite of active-low flags: low only when every device is low
    function automatic logic comp_flag(input logic [DEVS-1:0] flags_n);
        return |flags_n;
    endfunction : comp_flag

    logic empty_comp_n, full_comp_n;
    assign empty_comp_n = comp_flag(empty_s2_reg);
    assign full_comp_n = comp_flag(full_s2_reg);

    // first device of a chain loads first, the rest wait; the devices hand
    // ownership along their own expansion ring, so no chain pin comes here
    for (genvar i = 0; i < DEVS; i++) begin : g_first_load
        assign first_load_select_out[i] = (i != 0);
    end

    // ----------------------------------------
    // two-entry read buffer
    // ----------------------------------------
    logic [W-1:0] buf_mem_reg [`AFMEC_BUF_DEPTH];
    logic [W-1:0] buf_mem_next [`AFMEC_BUF_DEPTH];
    logic buf_wr_reg, buf_wr_next, buf_rd_reg, buf_rd_next;
    logic [1:0] buf_cnt_reg, buf_cnt_next;
    logic push, pop;

    assign pop = rd_valid_out && rd_ready_in;
    assign rd_valid_out = (buf_cnt_reg != 2'h0);
    assign rd_data_out = buf_mem_reg[buf_rd_reg];

    always_comb begin
        buf_mem_next = buf_mem_reg;
        buf_wr_next = buf_wr_reg;
        buf_rd_next = buf_rd_reg;
        buf_cnt_next = buf_cnt_reg;
        if (push) begin
            buf_mem_next[buf_wr_reg] = data_s2_reg;
            buf_wr_next = ~buf_wr_reg;
        end
        if (pop) begin
            buf_rd_next = ~buf_rd_reg;
        end
        if (push && !pop) begin
            buf_cnt_next = buf_cnt_reg + 2'h1;
        end else if (pop && !push) begin
            buf_cnt_next = buf_cnt_reg - 2'h1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        buf_mem_reg <= buf_mem_next;
        if (!rst_n_in) begin
            buf_wr_reg <= 1'b0;
            buf_rd_reg <= 1'b0;
            buf_cnt_reg <= 2'h0;
        end else begin
            buf_wr_reg <= buf_wr_next;
            buf_rd_reg <= buf_rd_next;
            buf_cnt_reg <= buf_cnt_next;
        end
    end

    // ----------------------------------------
    // strobe sequencer
    // ----------------------------------------
    afmec_state_t state_reg, state_next;
    afmec_strobes_t ctrl_reg, ctrl_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [W-1:0] wdata_reg, wdata_next;
    logic prefer_rd_reg, prefer_rd_next;
    logic rt_go, rd_go, wr_go;

    // retransmit does not exist on a chained device
    assign rt_go = retransmit_req_in && SINGLE;
    // a read is only started on a non-empty fifo with buffer room
    assign rd_go = empty_comp_n && (buf_cnt_reg != 2'h2);
    // a write strobe is only started while full is deasserted
    assign wr_go = wr_valid_in && full_comp_n;
    assign wr_ready_out = (state_reg == AFMEC_ST_IDLE) && !reset_req_in && !rt_go
                          && full_comp_n && !(rd_go && prefer_rd_reg);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg + 4'h1;
        wdata_next = wdata_reg;
        prefer_rd_next = prefer_rd_reg;
        push = 1'b0;
        case (state_reg)
            AFMEC_ST_RESET: begin
                if (cnt_reg == RESET_CYC - 4'h1) begin
                    state_next = AFMEC_ST_RECOV;
                    cnt_next = 4'h0;
                end
            end
            AFMEC_ST_IDLE: begin
                cnt_next = 4'h0;
                if (reset_req_in) begin
                    state_next = AFMEC_ST_RESET;
                end else if (rt_go) begin
                    state_next = AFMEC_ST_RETRANS;
                end else if (rd_go && (prefer_rd_reg || !wr_go)) begin
                    state_next = AFMEC_ST_READ;
                    prefer_rd_next = 1'b0;
                end else if (wr_go) begin
                    state_next = AFMEC_ST_WRITE;
                    wdata_next = wr_data_in;
                    prefer_rd_next = 1'b1;
                end
            end
            AFMEC_ST_WRITE, AFMEC_ST_RETRANS: begin
                if (cnt_reg == STROBE_CYC - 4'h1) begin
                    state_next = AFMEC_ST_RECOV;
                    cnt_next = 4'h0;
                end
            end
            AFMEC_ST_READ: begin
                // sample late in the pulse so the synchroniser holds the word
                if (cnt_reg == STROBE_CYC - 4'h1) begin
                    push = 1'b1;
                    state_next = AFMEC_ST_RECOV;
                    cnt_next = 4'h0;
                end
            end
            AFMEC_ST_RECOV: begin
                // recovery also lets the flags settle through the synchroniser
                if (cnt_reg == RECOV_CYC - 4'h1) begin
                    state_next = AFMEC_ST_IDLE;
                    cnt_next = 4'h0;
                end
            end
            default: begin
                state_next = AFMEC_ST_RESET;
                cnt_next = 4'h0;
            end
        endcase
        ctrl_next = '{pointer_reset_n: 1'b1, write_n: 1'b1, read_n: 1'b1,
                      retransmit_strobe_n: 1'b1};
        case (state_next)
            AFMEC_ST_RESET: ctrl_next.pointer_reset_n = 1'b0;
            AFMEC_ST_WRITE: ctrl_next.write_n = 1'b0;
            AFMEC_ST_READ: ctrl_next.read_n = 1'b0;
            AFMEC_ST_RETRANS: ctrl_next.retransmit_strobe_n = 1'b0;
            default: ctrl_next = ctrl_next;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            // a pointer reset is mandatory after power up
            state_reg <= AFMEC_ST_RESET;
            cnt_reg <= 4'h0;
            ctrl_reg <= '{pointer_reset_n: 1'b0, write_n: 1'b1, read_n: 1'b1,
                          retransmit_strobe_n: 1'b1};
            wdata_reg <= '0;
            prefer_rd_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            ctrl_reg <= ctrl_next;
            wdata_reg <= wdata_next;
            prefer_rd_reg <= prefer_rd_next;
        end
    end

    assign fifo_ctrl_out = ctrl_reg;
    // data is held through recovery to cover hold after the write edge
    assign fifo_data_out = wdata_reg;
    assign busy_out = (state_reg != AFMEC_ST_IDLE);
    assign status_out = '{empty: !empty_comp_n, full: !full_comp_n,
                          half_full: SINGLE && !half_s2_reg};

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_write_not_full;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        $fell(ctrl_reg.write_n) |-> $past(full_comp_n);
    endproperty
    a_write_not_full: assert property (p_write_not_full)
        else $error("write strobe started while full");

    property p_read_not_empty;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        $fell(ctrl_reg.read_n) |-> $past(empty_comp_n) && $past(buf_cnt_reg) != 2'h2;
    endproperty
    a_read_not_empty: assert property (p_read_not_empty)
        else $error("read strobe started while empty or buffer full");

    property p_rt_strobes_high;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        !ctrl_reg.retransmit_strobe_n |-> ctrl_reg.write_n && ctrl_reg.read_n;
    endproperty
    a_rt_strobes_high: assert property (p_rt_strobes_high)
        else $error("read or write low during retransmit");

    property p_reset_pulse;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        $fell(ctrl_reg.pointer_reset_n) |->
            (!ctrl_reg.pointer_reset_n && ctrl_reg.write_n && ctrl_reg.read_n)[*5]
            ##1 ctrl_reg.pointer_reset_n;
    endproperty
    a_reset_pulse: assert property (p_reset_pulse)
        else $error("pointer reset pulse wrong length or strobes active");

    property p_write_pulse;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        $fell(ctrl_reg.write_n) |-> !ctrl_reg.write_n[*4] ##1 ctrl_reg.write_n[*3];
    endproperty
    a_write_pulse: assert property (p_write_pulse)
        else $error("write strobe width or recovery wrong");

    property p_no_rt_chain;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        !SINGLE |-> ctrl_reg.retransmit_strobe_n && !status_out.half_full;
    endproperty
    a_no_rt_chain: assert property (p_no_rt_chain)
        else $error("retransmit or half-full used in a chain");

    property p_first_load;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        first_load_select_out == {{(DEVS-1){1'b1}}, 1'b0};
    endproperty
    a_first_load: assert property (p_first_load)
        else $error("first-load selection not unique");

    property p_read_push;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        $fell(ctrl_reg.read_n) |-> ##3 push ##1 (buf_cnt_reg != 2'h0);
    endproperty
    a_read_push: assert property (p_read_push)
        else $error("read word not captured into buffer");

    c_write: cover property (@(posedge sys_clk_in) $rose(ctrl_reg.write_n));
    c_read: cover property (@(posedge sys_clk_in) $rose(ctrl_reg.read_n));
    c_retransmit: cover property (@(posedge sys_clk_in) $fell(ctrl_reg.retransmit_strobe_n));
    c_buf_full: cover property (@(posedge sys_clk_in) buf_cnt_reg == 2'h2 && !rd_ready_in);
endmodule : afmec_host

//--- afmec_dev_model.sv
module afmec_dev_model
    import afmec_pkg::*;
#(
    parameter int DEPTH = 256
) (
    input wire afmec_strobes_t ctrl_in,
    input wire logic [8:0] d_in,
    input wire logic first_load_select_in,
    input wire logic expansion_chain_input_in,
    output logic [8:0] q_out,
    output logic empty_flag_n_out,
    output logic full_flag_n_out,
    output logic half_full_flag_n_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // chain input is grounded by the bench, so this is one device of DEPTH words
    logic [8:0] mem [DEPTH];
    int unsigned wptr = 0, rptr = 0, count = 0, strobe_err = 0;
    bit wr_act = 0, rd_act = 0;

    always @(ctrl_in) begin
        if (!ctrl_in.pointer_reset_n) begin
            wptr = 0;
            rptr = 0;
            count = 0;
            wr_act = 0;
            rd_act = 0;
        end else if (!ctrl_in.retransmit_strobe_n) begin
            if (!ctrl_in.write_n || !ctrl_in.read_n) strobe_err++;
            rptr = 0;
            count = wptr;
        end
    end
    always @(negedge ctrl_in.write_n) wr_act = ctrl_in.pointer_reset_n && count < DEPTH;
    always @(posedge ctrl_in.write_n) begin
        if (wr_act) begin
            mem[wptr] = d_in;
            wptr = (wptr + 1) % DEPTH;
            count++;
        end
        wr_act = 0;
    end
    always @(negedge ctrl_in.read_n) rd_act = ctrl_in.pointer_reset_n && count > 0;
    always @(posedge ctrl_in.read_n) begin
        if (rd_act) begin
            rptr = (rptr + 1) % DEPTH;
            count--;
        end
        rd_act = 0;
    end
    // released outputs show the inverted word so stale data never passes
    assign q_out = (rd_act && !ctrl_in.read_n) ? mem[rptr] : ~mem[rptr];
    assign empty_flag_n_out = (count != 0);
    assign full_flag_n_out = (count != DEPTH);
    assign half_full_flag_n_out = !(count > DEPTH / 2);
endmodule : afmec_dev_model

//--- tb.sv
module tb
    import afmec_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DEPTH = 256;
    logic sys_clk_in = 0, rst_n_in = 0, reset_req = 0, retr_req = 0, wr_valid = 0, rd_ready = 0;
    logic [8:0] wr_data = '0, rd_data, fdo, fdi;
    logic wr_ready, rd_valid, busy, efn, ffn, hfn;
    logic [0:0] fls;
    afmec_status_t status;
    afmec_strobes_t ctrl;
    logic [8:0] exp_q[$], got_q[$];
    int n_fail = 0, checked = 0, taken = 0;
    int unsigned wp;
    bit drain = 0, ok = 1, rd_take = 0;

    afmec_host #(.DEVS(1), .LANES(1), .DEV_DEPTH(DEPTH)) i_afmec_host (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reset_req_in(reset_req),
        .retransmit_req_in(retr_req), .wr_valid_in(wr_valid), .wr_data_in(wr_data),
        .wr_ready_out(wr_ready), .rd_valid_out(rd_valid), .rd_data_out(rd_data),
        .rd_ready_in(rd_ready), .status_out(status), .busy_out(busy), .fifo_ctrl_out(ctrl),
        .fifo_data_out(fdo), .fifo_data_in(fdi), .empty_flag_n_in(efn),
        .full_flag_n_in(ffn), .half_full_flag_n_in(hfn), .first_load_select_out(fls));
    afmec_dev_model #(.DEPTH(DEPTH)) i_afmec_dev_model (
        .ctrl_in(ctrl), .d_in(fdo), .first_load_select_in(fls[0]),
        .expansion_chain_input_in(1'b0), .q_out(fdi), .empty_flag_n_out(efn),
        .full_flag_n_out(ffn), .half_full_flag_n_out(hfn));

    always #10 sys_clk_in = ~sys_clk_in;

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        checked++;
        if (seen !== expd) begin
            n_fail++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, expd);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict

    // ready is combinational, so it is read once the falling-edge drive has settled
    task automatic push(input logic [8:0] w, output bit acc);
        acc = 0;
        @(negedge sys_clk_in);
        wr_valid = 1;
        wr_data = w;
        for (int i = 0; i < 20 && !acc; i++) begin
            #1;
            if (wr_ready === 1'b1) acc = 1;
            else @(negedge sys_clk_in);
        end
        if (!acc) wr_valid = 0;
        else begin
            exp_q.push_back(w);
            @(posedge sys_clk_in);
        end
    endtask : push

    task automatic put_n(input int n);
        bit acc;
        for (int i = 0; i < n; i++) begin
            push(9'($urandom), acc);
            check(acc, 1);
        end
        @(negedge sys_clk_in);
        wr_valid = 0;
        repeat (40) @(negedge sys_clk_in);
    endtask : put_n

    task automatic wait_idle();
        repeat (12) @(negedge sys_clk_in);
        for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge sys_clk_in);
    endtask : wait_idle

    task automatic pulse(ref logic req);
        @(negedge sys_clk_in);
        req = 1;
        @(negedge sys_clk_in);
        req = 0;
        wait_idle();
    endtask : pulse

    task automatic drain_all(input int n);
        @(posedge sys_clk_in);
        drain = 1;
        for (int i = 0; i < 20000 && got_q.size() < n; i++) @(posedge sys_clk_in);
        drain = 0;
        check(got_q.size(), n);
        for (int i = 0; i < n && i < got_q.size(); i++) check(got_q[i], exp_q[i]);
        got_q.delete();
        exp_q.delete();
        repeat (10) @(posedge sys_clk_in);
    endtask : drain_all

    // receiver stalls at random while draining; the word is logged together with
    // the ready about to be shown, because the pop happens at the next rising edge
    always @(negedge sys_clk_in) begin
        rd_take = drain && ($urandom_range(0, 3) != 0);
        if (rd_valid === 1'b1 && rd_take) got_q.push_back(rd_data);
        rd_ready <= rd_take;
    end

    initial begin
        #(20ns * 40000);
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        void'($urandom(83));
        repeat (5) @(negedge sys_clk_in);
        check(ctrl.pointer_reset_n, 0);
        rst_n_in = 1;
        wait_idle();
        check(status, 3'b100);
        $display("test reset done");
        push(9'h000, ok);
        push(9'h1FF, ok);
        put_n(4);
        check(rd_valid, 1);
        check(i_afmec_dev_model.count, 4);
        drain_all(6);
        check(status, 3'b100);
        $display("test stream done");
        while (ok) begin
            push(9'($urandom), ok);
            if (ok) taken++;
        end
        repeat (40) @(negedge sys_clk_in);
        check(taken, DEPTH + 2);
        check(status, 3'b011);
        drain_all(DEPTH + 2);
        $display("test fill done");
        put_n(4);
        pulse(reset_req);
        check(i_afmec_dev_model.count, 0);
        check(status, 3'b100);
        check(fls, 1'b0);
        exp_q = exp_q[0:1];
        drain_all(2);
        $display("test pointer reset done");
        // retransmit restarts at location zero, so it only replays what was
        // written since the pointer reset above
        put_n(3);
        wp = i_afmec_dev_model.wptr;
        pulse(retr_req);
        check(i_afmec_dev_model.rptr, 0);
        check(i_afmec_dev_model.wptr, wp);
        check(i_afmec_dev_model.strobe_err, 0);
        exp_q = {exp_q[0], exp_q[1], exp_q};
        drain_all(5);
        $display("test retransmit done");
        give_verdict();
    end
endmodule : tb
